// ---- gida_cfg.svh ----
// Constants of the gateway input data set assembler.
//
// Behaviour
// - Process-data set length is configurable up to fifty bytes, preset layout modifiable.
// - Token fieldbus variant splits the process set into 4x12-byte blocks plus 2 bytes.
// - CANopen variant splits the process set into four blocks of eight bytes.
// - Checksum set is 32 bytes: project CRC 0-3, internal CRC 4-7, rest reserved.
// - Module state set is 60 bytes, controller takes bytes 0 to 11.
// - Fourth data set has sixty bytes, all filled with reserved values.
// - Multibit 16 and 32 bit values may be mapped besides single bits.
// - CANopen variant serves checksum and state sets only by acyclic object reads.
// - Object Ethernet: class 120 instances 2 and 3, assembly 167 bytes 52-111.
// - Process bytes 0-3 hold controller inputs, bidirectional inputs and outputs.
// - Process bytes 12 to 23 hold input values of expansion modules 1 to 12.
// - Process bytes 24 to 35 hold output values of modules 1 to 12.
// - Controller state set bytes: state, test pulse, dual input, stuck-at, reserved.
// - Each expansion module has four state bytes starting at byte 12.
// - In controller error state values read zero and status bits read one.
// - State bits are zero for error, one for no error; reserved bits one.
`ifndef GIDA_CFG_SVH
`define GIDA_CFG_SVH
`define GIDA_DS1_MAX   6'h32
`define GIDA_DS2_LEN   8'h20
`define GIDA_DS3_LEN   8'h3c
`define GIDA_CRC_INT   8'h04
`define GIDA_CRC_END   8'h08
`define GIDA_CTL_END   8'h0c
`define GIDA_TOK_BLK   6'h0c
`define GIDA_TOK_LAST  6'h02
`define GIDA_TOK_NBLK  3'h5
`define GIDA_CAN_BLK   6'h08
`define GIDA_CAN_NBLK  3'h4
`define GIDA_SRC_DIR   6'h04
`define GIDA_SRC_MIN   6'h0c
`define GIDA_SRC_MOUT  6'h18
`define GIDA_SRC_M16   6'h24
`define GIDA_SRC_M32   6'h26
`define GIDA_SRC_END   6'h2a
`define GIDA_SRC_NONE  6'h3f
`define GIDA_OBJ_CLASS 8'h78
`define GIDA_ASM_CLASS 8'h04
`define GIDA_ASM_INST  8'ha7
`define GIDA_ASM_FIRST 8'h34
`define GIDA_ASM_LAST  8'h6f
`define GIDA_RSV_STATE 8'hff
`define GIDA_DEF_VALUE 8'h00
`define GIDA_OFF_CTRL  12'h000
`define GIDA_OFF_LEN   12'h004
`define GIDA_OFF_STAT  12'h008
`define GIDA_OFF_ISTAT 12'h00c
`define GIDA_OFF_IMASK 12'h010
`define GIDA_PAGE_MAP  4'h1
`define GIDA_PAGE_SET  4'h2
`define GIDA_CTRL_RST  4'h0
`define GIDA_NEV       4
`endif

// ---- gida_pkg.sv ----
// Types shared by the gateway input data set assembler.
package gida_pkg;
  typedef enum logic [2:0] {
    VAR_TCP   = 3'h0,
    VAR_TOKEN = 3'h1,
    VAR_CAN   = 3'h2,
    VAR_OBJ   = 3'h3,
    VAR_FRAME = 3'h4
  } gida_variant_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } gida_state_t;
  typedef struct packed {
    logic [3:0][7:0]  ctl;
    logic [7:0][7:0]  direct;
    logic [11:0][7:0] mod_in;
    logic [11:0][7:0] mod_out;
    logic [15:0]      mb16;
    logic [31:0]      mb32;
  } gida_proc_t;
  typedef struct packed {
    logic [3:0][7:0]       crc_proj;
    logic [3:0][7:0]       crc_int;
    logic [1:0][7:0]       ctl_stat;
    logic [2:0][7:0]       pulse_cmp;
    logic [1:0][7:0]       dual_in;
    logic [1:0][7:0]       stuck;
    logic [11:0][3:0][7:0] mod_state;
  } gida_diag_t;
endpackage

// ---- gida_block_split.sv ----
// Block layout of the process-data set per fieldbus variant.
`timescale 1ns/100ps
`include "gida_cfg.svh"
module gida_block_split (
  // Selection
  input  wire gida_pkg::gida_variant_t variant,
  input  wire logic [2:0]              blk_num,
  input  wire logic [5:0]              ds1_len,
  // Result
  output wire logic [5:0]              blk_start,
  output wire logic [5:0]              blk_len,
  output wire logic                    blk_ok
);
  import gida_pkg::*;

  wire tok = (variant == VAR_TOKEN);
  wire can = (variant == VAR_CAN);
  wire tok_last = (blk_num == 3'(`GIDA_TOK_NBLK - 3'h1));

  // Other variants carry the whole set as one block.
  assign blk_ok = tok ? (blk_num < `GIDA_TOK_NBLK) :
                  can ? (blk_num < `GIDA_CAN_NBLK) : (blk_num == 3'h0);
  assign blk_start = tok ? 6'(blk_num * `GIDA_TOK_BLK) :
                     can ? 6'(blk_num * `GIDA_CAN_BLK) : 6'h00;
  assign blk_len = tok ? (tok_last ? `GIDA_TOK_LAST : `GIDA_TOK_BLK) :
                   can ? `GIDA_CAN_BLK : ds1_len;
endmodule

// ---- gida_assembler.sv ----
// Gateway input data set assembler with APB registers and two master ports.
`timescale 1ns/100ps
`include "gida_cfg.svh"
module gida_assembler (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic [11:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // System data
  input  wire gida_pkg::gida_proc_t proc,
  input  wire gida_pkg::gida_diag_t diag,
  input  wire logic                 ctrl_error,
  // Cyclic block stream
  input  wire logic                 blk_req,
  input  wire logic [2:0]           blk_num,
  input  wire logic                 tx_ready,
  output logic                      tx_valid,
  output logic      [7:0]           tx_data,
  output logic                      tx_last,
  // Acyclic object read
  input  wire logic                 obj_req,
  input  wire logic [7:0]           obj_class,
  input  wire logic [7:0]           obj_inst,
  input  wire logic [7:0]           obj_index,
  output logic                      obj_ack,
  output logic                      obj_err,
  output logic      [7:0]           obj_data,
  // Interrupt
  output logic                      irq
);
  import gida_pkg::*;

  gida_variant_t         variant;
  logic                  mb_en;
  logic [5:0]            ds1_len;
  logic [5:0]            map_tab [50];
  logic [`GIDA_NEV-1:0]  istat;
  logic [`GIDA_NEV-1:0]  imask;
  logic                  err_d;
  gida_state_t           state;
  logic [5:0]            tx_ptr;
  logic [5:0]            tx_rem;
  logic [5:0]            xfer_len;
  logic [5:0]            tx_cnt;
  wire  [5:0]            blk_start;
  wire  [5:0]            blk_len;
  wire                   blk_ok;
  logic [32:0]           rd_word;
  logic [10:0]           route;

  // Source pool of the process set; mapping selects one byte per position.
  function automatic logic [7:0] src_byte(input logic [5:0] c);
    logic [7:0] b;
    b = `GIDA_DEF_VALUE;
    if (c < `GIDA_SRC_DIR) begin
      b = proc.ctl[c[1:0]];
    end else if (c < `GIDA_SRC_MIN) begin
      b = proc.direct[3'(c - `GIDA_SRC_DIR)];
    end else if (c < `GIDA_SRC_MOUT) begin
      b = proc.mod_in[4'(c - `GIDA_SRC_MIN)];
    end else if (c < `GIDA_SRC_M16) begin
      b = proc.mod_out[4'(c - `GIDA_SRC_MOUT)];
    end else if (c < `GIDA_SRC_M32 && mb_en) begin
      b = c[0] ? proc.mb16[15:8] : proc.mb16[7:0];
    end else if (c < `GIDA_SRC_END && mb_en) begin
      b = proc.mb32[{c[1:0] ^ 2'b10, 3'b000} +: 8];
    end
    if (ctrl_error) begin
      b = `GIDA_DEF_VALUE;
    end
    return b;
  endfunction

  function automatic logic [7:0] ds1_byte(input logic [7:0] i);
    logic [7:0] b;
    b = `GIDA_DEF_VALUE;
    if (i < 8'(ds1_len)) begin
      b = src_byte(map_tab[i[5:0]]);
    end
    return b;
  endfunction

  // State set; a status bit of one means no error.
  function automatic logic [7:0] ds3_byte(input logic [7:0] i);
    logic [7:0] b;
    logic [7:0] m;
    m = i - `GIDA_CTL_END;
    b = `GIDA_RSV_STATE;
    if (i >= `GIDA_CTL_END) begin
      b = diag.mod_state[m[5:2]][m[1:0]];
    end else begin
      case (i[3:0])
        4'h0, 4'h1: b = diag.ctl_stat[i[0]];
        4'h2, 4'h3, 4'h4: b = diag.pulse_cmp[2'(i[3:0] - 4'h2)];
        4'h5, 4'h6: b = diag.dual_in[~i[0]];
        4'h8, 4'h9: b = diag.stuck[i[0]];
        default: b = `GIDA_RSV_STATE;
      endcase
    end
    if (ctrl_error) begin
      b = `GIDA_RSV_STATE;
    end
    return b;
  endfunction

  function automatic logic [7:0] set_byte(input logic [2:0] s, input logic [7:0] i);
    logic [7:0] b;
    b = `GIDA_DEF_VALUE;
    case (s)
      3'h1: b = ds1_byte(i);
      3'h2: begin
        if (i < `GIDA_CRC_INT) begin
          b = diag.crc_proj[i[1:0]];
        end else if (i < `GIDA_CRC_END) begin
          b = diag.crc_int[i[1:0]];
        end
      end
      3'h3: b = (i < `GIDA_DS3_LEN) ? ds3_byte(i) : `GIDA_DEF_VALUE;
      3'h4: b = (i < `GIDA_DS3_LEN) ? `GIDA_RSV_STATE : `GIDA_DEF_VALUE;
      default: b = `GIDA_DEF_VALUE;
    endcase
    return b;
  endfunction

  // Resolves an acyclic request to {set, byte}; set zero means refused.
  function automatic logic [10:0] obj_route(input logic [7:0] cls,
                                            input logic [7:0] inst,
                                            input logic [7:0] idx);
    logic [2:0] s;
    logic [7:0] j;
    logic [7:0] len;
    s = 3'h0;
    j = idx;
    case (variant)
      VAR_TOKEN: s = 3'h0;
      VAR_CAN: begin
        if (inst == 8'h02 || inst == 8'h03) begin
          s = inst[2:0];
        end
      end
      VAR_OBJ: begin
        if (cls == `GIDA_OBJ_CLASS && (inst == 8'h02 || inst == 8'h03)) begin
          s = inst[2:0];
        end else if (cls == `GIDA_ASM_CLASS && inst == `GIDA_ASM_INST &&
                     idx >= `GIDA_ASM_FIRST && idx <= `GIDA_ASM_LAST) begin
          s = 3'h3;
          j = idx - `GIDA_ASM_FIRST;
        end
      end
      VAR_FRAME: s = (inst >= 8'h01 && inst <= 8'h03) ? inst[2:0] : 3'h0;
      default: s = (inst >= 8'h01 && inst <= 8'h04) ? inst[2:0] : 3'h0;
    endcase
    len = (s == 3'h1) ? 8'(ds1_len) : (s == 3'h2) ? `GIDA_DS2_LEN : `GIDA_DS3_LEN;
    if (j >= len) begin
      s = 3'h0;
    end
    return {s, j};
  endfunction

  // Register read decode: {hit, data}.
  function automatic logic [32:0] apb_rd(input logic [11:0] a);
    logic [32:0] r;
    logic [7:0]  w;
    logic [2:0]  s;
    w = {2'b00, a[5:2], 2'b00};
    s = {1'b0, a[7:6]} + 3'h1;
    r = {1'b0, 32'h0000_0000};
    if (a[1:0] != 2'b00) begin
      r = {1'b0, 32'h0000_0000};
    end else if (a == `GIDA_OFF_CTRL) begin
      r = {1'b1, 28'h0000000, mb_en, variant};
    end else if (a == `GIDA_OFF_LEN) begin
      r = {1'b1, 26'h0000000, ds1_len};
    end else if (a == `GIDA_OFF_STAT) begin
      r = {1'b1, 30'h00000000, state == ST_SEND, ctrl_error};
    end else if (a == `GIDA_OFF_ISTAT) begin
      r = {1'b1, 28'h0000000, istat};
    end else if (a == `GIDA_OFF_IMASK) begin
      r = {1'b1, 28'h0000000, imask};
    end else if (a[11:8] == `GIDA_PAGE_MAP && a[7:2] < `GIDA_DS1_MAX) begin
      r = {1'b1, 26'h0000000, map_tab[a[7:2]]};
    end else if (a[11:8] == `GIDA_PAGE_SET) begin
      r = {1'b1, set_byte(s, w + 8'h03), set_byte(s, w + 8'h02),
           set_byte(s, w + 8'h01), set_byte(s, w)};
    end
    return r;
  endfunction

  gida_block_split u_split (
    .variant   (variant),
    .blk_num   (blk_num),
    .ds1_len   (ds1_len),
    .blk_start (blk_start),
    .blk_len   (blk_len),
    .blk_ok    (blk_ok)
  );

  // A process also wakes on the registers that the decode functions read.
  always_comb rd_word = apb_rd(paddr);
  wire        apb_do  = psel && penable && pready;
  wire        wr_ctrl = apb_do && pwrite && paddr == `GIDA_OFF_CTRL;
  wire        wr_len  = apb_do && pwrite && paddr == `GIDA_OFF_LEN;
  wire        wr_ist  = apb_do && pwrite && paddr == `GIDA_OFF_ISTAT;
  wire        wr_imk  = apb_do && pwrite && paddr == `GIDA_OFF_IMASK;
  wire        wr_map  = apb_do && pwrite && paddr[11:8] == `GIDA_PAGE_MAP &&
                        paddr[1:0] == 2'b00 && paddr[7:2] < `GIDA_DS1_MAX;
  wire [5:0]  next_len = (pwdata[31:0] > 32'(`GIDA_DS1_MAX)) ? `GIDA_DS1_MAX
                                                            : pwdata[5:0];
  wire        idle     = (state == ST_IDLE);
  wire        blk_take = blk_req && idle && blk_ok && blk_len != 6'h00;
  wire        tx_fire  = tx_valid && tx_ready;
  always_comb route = obj_route(obj_class, obj_inst, obj_index);
  wire [2:0]  rset     = route[10:8];
  wire [7:0]  ridx     = route[7:0];
  wire [`GIDA_NEV-1:0] ev = {tx_fire && tx_last, ctrl_error && !err_d,
                             obj_req && rset == 3'h0, blk_req && !blk_take};
  wire [`GIDA_NEV-1:0] next_istat = (istat & ~(wr_ist ? pwdata[`GIDA_NEV-1:0]
                                                      : '0)) | ev;

  // One wait state keeps the decode off the bus timing path.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_word[31:0];
        pslverr <= !rd_word[32];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      variant <= VAR_TCP;
      mb_en   <= 1'b0;
      ds1_len <= `GIDA_DS1_MAX;
      imask   <= '0;
    end else begin
      if (wr_ctrl) begin
        variant <= gida_variant_t'(pwdata[2:0]);
        mb_en   <= pwdata[3];
      end
      if (wr_len) begin
        ds1_len <= next_len;
      end
      if (wr_imk) begin
        imask <= pwdata[`GIDA_NEV-1:0];
      end
    end
  end

  // Preset layout maps the documented sources one to one; the tail is unallocated.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 50; i++) begin
        map_tab[i] <= (i < 36) ? 6'(i) : `GIDA_SRC_NONE;
      end
    end else if (wr_map) begin
      map_tab[paddr[7:2]] <= pwdata[5:0];
    end
  end

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat <= '0;
      err_d <= 1'b0;
      irq   <= 1'b0;
    end else begin
      istat <= next_istat;
      err_d <= ctrl_error;
      irq   <= |(next_istat & imask);
    end
  end

  // Block stream; bytes are sampled as each one is offered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ST_IDLE;
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      tx_last  <= 1'b0;
      tx_ptr   <= 6'h00;
      tx_rem   <= 6'h00;
      xfer_len <= 6'h00;
      tx_cnt   <= 6'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (blk_take) begin
            state    <= ST_SEND;
            tx_valid <= 1'b1;
            tx_data  <= ds1_byte(8'(blk_start));
            tx_last  <= (blk_len == 6'h01);
            tx_ptr   <= blk_start + 6'h01;
            tx_rem   <= blk_len - 6'h01;
            xfer_len <= blk_len;
            tx_cnt   <= 6'h00;
          end
        end
        ST_SEND: begin
          if (tx_fire) begin
            tx_cnt <= tx_cnt + 6'h01;
            if (tx_last) begin
              state    <= ST_IDLE;
              tx_valid <= 1'b0;
              tx_last  <= 1'b0;
            end else begin
              tx_data <= ds1_byte(8'(tx_ptr));
              tx_last <= (tx_rem == 6'h01);
              tx_ptr  <= tx_ptr + 6'h01;
              tx_rem  <= tx_rem - 6'h01;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Acyclic answer follows one edge after the request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      obj_ack  <= 1'b0;
      obj_err  <= 1'b0;
      obj_data <= 8'h00;
    end else begin
      obj_ack  <= obj_req;
      obj_err  <= obj_req && rset == 3'h0;
      obj_data <= (obj_req && rset != 3'h0) ? set_byte(rset, ridx) : 8'h00;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_LEN_MAX: assert property (ds1_len <= `GIDA_DS1_MAX)
    else $error("process set length above limit");
  AST_TOKEN_BLK: assert property (blk_take && variant == VAR_TOKEN
    |=> xfer_len == (($past(blk_num) == 3'h4) ? 6'h02 : 6'h0c))
    else $error("token block size wrong");
  AST_CAN_BLK: assert property (blk_take && variant == VAR_CAN |=> xfer_len == 6'h08)
    else $error("CANopen block size wrong");
  AST_XFER_CNT: assert property (tx_fire && tx_last |-> tx_cnt + 6'h01 == xfer_len)
    else $error("block byte count wrong");
  AST_CRC_INT: assert property (obj_req && rset == 3'h2 && ridx == 8'h04
    |=> !obj_err && obj_data == $past(diag.crc_int[0]))
    else $error("internal checksum byte misplaced");
  AST_MOD1_STATE: assert property (obj_req && rset == 3'h3 && ridx == 8'h0c &&
    !ctrl_error |=> obj_data == $past(diag.mod_state[0][0]))
    else $error("module one state misplaced");
  AST_SET4_RSV: assert property (obj_req && rset == 3'h4 |=> obj_ack ##0 obj_data == 8'hff)
    else $error("reserved set not all ones");
  AST_CAN_SET1: assert property (obj_req && variant == VAR_CAN && obj_inst == 8'h01
    |=> obj_ack && obj_err)
    else $error("CANopen served process set acyclically");
  AST_ASM_MAP: assert property (obj_req && variant == VAR_OBJ &&
    obj_class == `GIDA_ASM_CLASS && obj_inst == `GIDA_ASM_INST && obj_index == 8'h34 &&
    !ctrl_error |=> !obj_err && obj_data == $past(diag.ctl_stat[0]))
    else $error("assembly byte 52 not state byte 0");
  AST_RSV_ONE: assert property (obj_req && rset == 3'h3 && ridx == 8'h07 |=> obj_data == 8'hff)
    else $error("reserved state byte not ones");
  AST_ERR_ZERO: assert property ((blk_take || (tx_fire && !tx_last)) && ctrl_error
    |=> tx_data == 8'h00)
    else $error("error state value not zero");
  AST_CTL_BYTE0: assert property (blk_take && blk_start == 6'h00 && map_tab[0] == 6'h00 &&
    !ctrl_error |=> tx_data == $past(proc.ctl[0]))
    else $error("controller inputs not at byte 0");

  COV_TOKEN_LAST: cover property (blk_take && variant == VAR_TOKEN && blk_num == 3'h4);
  COV_CAN_ACYC: cover property (obj_req && variant == VAR_CAN && rset == 3'h3);
  COV_ASM_READ: cover property (obj_req && variant == VAR_OBJ && obj_class == `GIDA_ASM_CLASS);
  COV_IRQ: cover property (irq);
endmodule

// ---- gida_master_model.sv ----
// Network master model that reads cyclic blocks and single bytes by object read.
`timescale 1ns/100ps
module gida_master_model (
  // Clock
  input  wire logic       pclk,
  // Cyclic block stream
  output logic            blk_req,
  output logic [2:0]      blk_num,
  output logic            tx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  // Acyclic object read
  output logic            obj_req,
  output logic [7:0]      obj_class,
  output logic [7:0]      obj_inst,
  output logic [7:0]      obj_index,
  input  wire logic       obj_ack,
  input  wire logic       obj_err,
  input  wire logic [7:0] obj_data
);
  logic [7:0] got [0:63];

  initial begin
    blk_req = 1'b0;
    blk_num = 3'h0;
    tx_ready = 1'b0;
    obj_req = 1'b0;
    obj_class = 8'h00;
    obj_inst = 8'h00;
    obj_index = 8'h00;
  end

  // Fields are inverted once the request is taken, so a late sample can never match.
  task automatic fetch_block(input logic [2:0] n, input logic stall, output int cnt);
    cnt = 0;
    @(posedge pclk);
    blk_req <= 1'b1;
    blk_num <= n;
    tx_ready <= ~stall;
    @(posedge pclk);
    blk_req <= 1'b0;
    blk_num <= ~n;
    for (int k = 0; k < 200; k++) begin
      @(posedge pclk);
      if (tx_valid && tx_ready) begin
        got[cnt] = tx_data;
        cnt++;
      end
      if (tx_valid && tx_ready && tx_last) begin
        tx_ready <= 1'b0;
        break;
      end
      tx_ready <= stall ? ~tx_ready : 1'b1;
    end
  endtask

  task automatic obj_read(input logic [7:0] c, input logic [7:0] i, input logic [7:0] x,
                          output logic ack, output logic err, output logic [7:0] d);
    @(posedge pclk);
    obj_req <= 1'b1;
    obj_class <= c;
    obj_inst <= i;
    obj_index <= x;
    @(posedge pclk);
    obj_req <= 1'b0;
    obj_class <= ~c;
    obj_inst <= ~i;
    obj_index <= ~x;
    #1;
    ack = obj_ack;
    err = obj_err;
    d = obj_data;
  endtask
endmodule

// ---- gida_assembler_test.sv ----
// Self-checking testbench of the gateway input data set assembler.
`timescale 1ns/100ps
module gida_assembler_test;
  import gida_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ctrl_error, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic        blk_req, tx_ready, tx_valid, tx_last, obj_req, obj_ack, obj_err, re;
  logic [2:0]  blk_num;
  logic [7:0]  tx_data, obj_class, obj_inst, obj_index, obj_data;
  gida_proc_t  proc;
  gida_diag_t  diag;
  int          err_count, n_compared, cyc, cnt;

  gida_assembler u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .proc(proc), .diag(diag), .ctrl_error(ctrl_error), .blk_req(blk_req),
    .blk_num(blk_num), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .obj_req(obj_req), .obj_class(obj_class), .obj_inst(obj_inst),
    .obj_index(obj_index), .obj_ack(obj_ack), .obj_err(obj_err), .obj_data(obj_data),
    .irq(irq));
  gida_master_model u_mst (.pclk(pclk), .blk_req(blk_req), .blk_num(blk_num),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .obj_req(obj_req), .obj_class(obj_class), .obj_inst(obj_inst), .obj_index(obj_index),
    .obj_ack(obj_ack), .obj_err(obj_err), .obj_data(obj_data));

  always #25 pclk = ~pclk;

  // The ceiling sits far above the roughly two thousand cycles the scenarios need.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [7:0] exp_byte(input int s, input int k, input logic fault);
    logic [7:0] b;
    b = k[7:0];
    if (s == 4 || (s == 3 && (fault || k == 7 || k == 10 || k == 11))) return 8'hff;
    if (s == 3) return b;
    if (s == 2) return (k < 8) ? 8'ha0 + b : 8'h00;
    if (fault) return 8'h00;
    if (k < 4) return 8'h10 + b;
    if (k < 12) return 8'h1c + b;
    if (k < 24) return 8'h34 + b;
    if (k < 36) return 8'h68 + b;
    return 8'h00;
  endfunction

  task automatic ochk(input logic [7:0] c, input logic [7:0] i, input logic [7:0] x,
                      input logic [7:0] e, input logic ee);
    logic       a;
    logic       r;
    logic [7:0] d;
    u_mst.obj_read(c, i, x, a, r, d);
    chk("obj ack", {31'h0, a}, 32'h1);
    chk("obj err", {31'h0, r}, {31'h0, ee});
    chk("obj data", {24'h0, d}, ee ? 32'h0 : {24'h0, e});
  endtask

  task automatic t_regs();
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", rv, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk("len reset", rv, 32'h32);
    apb(1'b1, 12'h004, 32'h3f);
    apb(1'b0, 12'h004, 32'h0);
    chk("len clamp", rv, 32'h32);
    apb(1'b0, 12'h244, 32'h0);
    chk("set window", rv, 32'ha7a6a5a4);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped err", {31'h0, re}, 32'h1);
  endtask

  task automatic t_sets(input logic fault);
    int len [1:4] = '{50, 32, 60, 60};
    for (int s = 1; s < 5; s++)
      for (int k = 0; k <= len[s]; k++)
        ochk(8'h00, s[7:0], k[7:0], exp_byte(s, k, fault), k == len[s]);
  endtask

  task automatic t_blocks(input logic [2:0] var_code, input int nblk, input int sz);
    apb(1'b1, 12'h000, {29'h0, var_code});
    for (int b = 0; b <= nblk; b++) begin
      u_mst.fetch_block(b[2:0], b[0], cnt);
      chk("block length", cnt, (b == nblk) ? 0 : (b == 4 ? 2 : sz));
      for (int i = 0; i < cnt; i++)
        chk("block byte", {24'h0, u_mst.got[i]}, {24'h0, exp_byte(1, sz * b + i, 1'b0)});
    end
  endtask

  task automatic t_routes();
    ochk(8'h00, 8'h02, 8'h04, 8'ha4, 1'b0);
    ochk(8'h00, 8'h03, 8'h0c, 8'h0c, 1'b0);
    ochk(8'h00, 8'h01, 8'h00, 8'h00, 1'b1);
    apb(1'b1, 12'h000, 32'h3);
    ochk(8'h78, 8'h02, 8'h00, 8'ha0, 1'b0);
    ochk(8'h78, 8'h03, 8'h05, 8'h05, 1'b0);
    ochk(8'h04, 8'ha7, 8'h34, 8'h00, 1'b0);
    ochk(8'h04, 8'ha7, 8'h6f, 8'h3b, 1'b0);
    ochk(8'h04, 8'ha7, 8'h70, 8'h00, 1'b1);
    ochk(8'h79, 8'h02, 8'h00, 8'h00, 1'b1);
  endtask

  task automatic t_multibit();
    apb(1'b1, 12'h190, 32'h24);
    apb(1'b1, 12'h000, 32'h0);
    ochk(8'h00, 8'h01, 8'h24, 8'h00, 1'b0);
    apb(1'b1, 12'h000, 32'h8);
    ochk(8'h00, 8'h01, 8'h24, 8'h6b, 1'b0);
  endtask

  // The refused block raises bit 0; the interrupt follows the mask one cycle late.
  task automatic t_irq();
    apb(1'b1, 12'h00c, 32'hf);
    apb(1'b1, 12'h000, 32'h1);
    u_mst.fetch_block(3'h5, 1'b0, cnt);
    apb(1'b0, 12'h00c, 32'h0);
    chk("refused flag", rv & 32'h1, 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, 12'h010, 32'h1);
    repeat (2) @(posedge pclk);
    #1 chk("irq raised", {31'h0, irq}, 32'h1);
    apb(1'b1, 12'h00c, 32'h1);
    repeat (2) @(posedge pclk);
    #1 chk("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b1, 12'h010, 32'h0);
  endtask

  task automatic t_fault();
    ctrl_error <= 1'b1;
    apb(1'b1, 12'h000, 32'h0);
    t_sets(1'b1);
    u_mst.fetch_block(3'h0, 1'b0, cnt);
    chk("fault block length", cnt, 32'h32);
    for (int i = 0; i < cnt; i++) chk("fault block byte", {24'h0, u_mst.got[i]}, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk("status error", rv, 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    chk("fault flag", rv & 32'h4, 32'h4);
    ctrl_error <= 1'b0;
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, ctrl_error} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    for (int i = 0; i < 4; i++) begin
      proc.ctl[i] = 8'h10 + 8'(i);
      diag.crc_proj[i] = 8'ha0 + 8'(i);
      diag.crc_int[i] = 8'ha4 + 8'(i);
    end
    for (int i = 0; i < 8; i++) proc.direct[i] = 8'h20 + 8'(i);
    for (int i = 0; i < 12; i++) begin
      proc.mod_in[i] = 8'h40 + 8'(i);
      proc.mod_out[i] = 8'h80 + 8'(i);
      for (int b = 0; b < 4; b++) diag.mod_state[i][b] = 8'(12 + 4 * i + b);
    end
    proc.mb16 = 16'h5a6b;
    proc.mb32 = 32'h01020304;
    diag.ctl_stat = 16'h0100;
    diag.pulse_cmp = 24'h040302;
    diag.dual_in = 16'h0605;
    diag.stuck = 16'h0908;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_sets(1'b0);
    t_blocks(3'h1, 5, 12);
    t_blocks(3'h2, 4, 8);
    t_routes();
    t_multibit();
    t_irq();
    t_fault();
    give_verdict();
  end
endmodule
